// ---- hdl/odsc_defs.svh ----
// constants of the octal converter serial control block
`ifndef ODSC_DEFS_SVH
`define ODSC_DEFS_SVH

`define ODSC_ADDR_W       8
`define ODSC_CTRL_OFS     8'h00
`define ODSC_STAT_OFS     8'h04
`define ODSC_DATA_BASE    8'h20
`define ODSC_CODE_BASE    8'h40
`define ODSC_CTRL_RST     1'b1
`define ODSC_CTRL_EN_BIT  0
`define ODSC_STAT_MODE    0
`define ODSC_STAT_BUSY    1
`define ODSC_STAT_ABORT   2
`define ODSC_NCH          8
`define ODSC_CODE_W       10
`define ODSC_FRAME_BITS   16
`define ODSC_ABORT_EDGES  8'h0e
`define ODSC_FULL_EDGES   8'h10
`define ODSC_CNT_MAX      8'hff
`define ODSC_OP_REG_ONLY  4'h8
`define ODSC_OP_WR_THRU   4'h9
`define ODSC_OP_UPD_ALL   4'ha
`define ODSC_OP_CHA_UPD   4'hb
`define ODSC_RESP_OKAY    2'b00
`define ODSC_RESP_SLVERR  2'b10

`endif

// ---- hdl/odsc_pkg.sv ----
// types of the octal converter serial control block
package odsc_pkg;
   typedef enum logic [1:0] {
      ODSC_IDLE  = 2'b01,
      ODSC_FRAME = 2'b10
   } odsc_state_e;

   typedef logic [9:0] odsc_code_t;
endpackage

// ---- hdl/odsc_sync3.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module odsc_sync3 #(
   parameter logic INIT = 1'b0
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic d,
   output logic      q
);
   logic f1;
   logic f2;
   logic f3;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         f1 <= INIT;
         f2 <= INIT;
         f3 <= INIT;
      end else begin
         f1 <= d;
         f2 <= f1;
         f3 <= f2;
      end
   end

   // a change counts once the second and third stage agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= INIT;
      end else if (f2 == f3) begin
         q <= f3;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/odsc_top.sv ----
// serial link, channel registers and register bus of the octal converter control
`timescale 1ns/1ps
`default_nettype none
`include "odsc_defs.svh"
module odsc_top (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   input  wire logic                        sclk,
   input  wire logic                        sync_n,
   input  wire logic                        din,
   output logic                             dout,
   output logic [7:0][9:0]                  dac_code,
   input  wire logic [`ODSC_ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [`ODSC_ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready
);
   logic                    sclk_f;
   logic                    sync_f;
   logic                    din_f;
   logic                    sclk_d;
   logic                    sync_d;
   odsc_pkg::odsc_state_e   st;
   logic [15:0]             shreg;
   logic [7:0]              cnt;
   logic [7:0][9:0]         data_reg;
   logic                    write_through_mode;
   logic                    link_en;
   logic                    last_abort;
   logic [7:0]              exec_count;
   logic                    sclk_fall;
   logic                    sync_fall;
   logic                    sync_rise;
   logic                    start;
   logic                    shift_en;
   logic                    exec;
   logic                    abort;
   logic [3:0]              op;
   logic [2:0]              ch;
   odsc_pkg::odsc_code_t    val;
   logic                    aw_got;
   logic                    w_got;
   logic [`ODSC_ADDR_W-1:0] aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;

   function automatic logic in_bank(input logic [`ODSC_ADDR_W-1:0] a,
                                    input logic [`ODSC_ADDR_W-1:0] base);
      in_bank = (a[`ODSC_ADDR_W-1:5] == base[`ODSC_ADDR_W-1:5]) && (a[1:0] == 2'b00);
   endfunction

   // serial clock parks high, so reset matches its idle level and no false edge follows
   odsc_sync3 #(.INIT(1'b1)) u_sclk (.clk(clk), .reset_n(reset_n), .d(sclk), .q(sclk_f));
   odsc_sync3 #(.INIT(1'b1)) u_sync (.clk(clk), .reset_n(reset_n), .d(sync_n), .q(sync_f));
   odsc_sync3 #(.INIT(1'b0)) u_din  (.clk(clk), .reset_n(reset_n), .d(din), .q(din_f));

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sclk_d <= 1'b1;
         sync_d <= 1'b1;
      end else begin
         sclk_d <= sclk_f;
         sync_d <= sync_f;
      end
   end

   assign sclk_fall = sclk_d & ~sclk_f;
   assign sync_fall = sync_d & ~sync_f;
   assign sync_rise = ~sync_d & sync_f;
   assign start     = (st == odsc_pkg::ODSC_IDLE) && sync_fall && link_en;
   // clock falls in the start cycle are ignored, covering a sloppy sync fall
   assign shift_en  = (st == odsc_pkg::ODSC_FRAME) && sclk_fall && !sync_f;
   assign abort     = (st == odsc_pkg::ODSC_FRAME) && sync_rise
                      && (cnt <= `ODSC_ABORT_EDGES);
   // whole multiples of sixteen edges up to 240 execute, so daisy chains work
   assign exec      = (st == odsc_pkg::ODSC_FRAME) && sync_rise
                      && (cnt >= `ODSC_FULL_EDGES) && (cnt[3:0] == 4'h0);
   assign op        = shreg[15:12];
   assign ch        = shreg[14:12];
   assign val       = shreg[11:2];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st <= odsc_pkg::ODSC_IDLE;
      end else begin
         case (st)
            odsc_pkg::ODSC_IDLE: begin
               if (start) begin
                  st <= odsc_pkg::ODSC_FRAME;
               end
            end
            odsc_pkg::ODSC_FRAME: begin
               if (sync_rise) begin
                  st <= odsc_pkg::ODSC_IDLE;
               end
            end
            default: begin
               st <= odsc_pkg::ODSC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         shreg <= 16'h0000;
      end else if (start) begin
         shreg <= 16'h0000;
      end else if (shift_en) begin
         shreg <= {shreg[14:0], din_f};
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt <= 8'h00;
      end else if (start) begin
         cnt <= 8'h00;
      end else if (shift_en && cnt != `ODSC_CNT_MAX) begin
         cnt <= cnt + 8'h01;
      end
   end

   // dout low for 14 edges, high on the 15th, then the bits received 15 edges back
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dout <= 1'b0;
      end else if (start) begin
         dout <= 1'b0;
      end else if (shift_en) begin
         if (cnt >= `ODSC_ABORT_EDGES + 8'h01) begin
            dout <= shreg[14];
         end else begin
            dout <= (cnt == `ODSC_ABORT_EDGES);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         write_through_mode <= 1'b0;
      end else if (exec && op == `ODSC_OP_REG_ONLY) begin
         write_through_mode <= 1'b0;
      end else if (exec && op == `ODSC_OP_WR_THRU) begin
         write_through_mode <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         data_reg <= '0;
      end else if (exec && !shreg[15]) begin
         data_reg[ch] <= val;
      end else if (exec && op == `ODSC_OP_CHA_UPD) begin
         data_reg[0] <= val;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dac_code <= '0;
      end else if (exec && !shreg[15] && write_through_mode) begin
         dac_code[ch] <= val;
      end else if (exec && op == `ODSC_OP_UPD_ALL) begin
         dac_code <= data_reg;
      end else if (exec && op == `ODSC_OP_CHA_UPD) begin
         dac_code    <= data_reg;
         dac_code[0] <= val;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         last_abort <= 1'b0;
         exec_count <= 8'h00;
      end else begin
         if (abort) begin
            last_abort <= 1'b1;
         end else if (exec) begin
            last_abort <= 1'b0;
         end
         if (exec) begin
            exec_count <= exec_count + 8'h01;
         end
      end
   end

   // register bus: write address and data taken in either order
   assign s_axi_awready = !aw_got && !s_axi_bvalid;
   assign s_axi_wready  = !w_got && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         aw_got       <= 1'b0;
         w_got        <= 1'b0;
         aw_addr      <= '0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ODSC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got  <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got  <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_got && w_got && !s_axi_bvalid) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `ODSC_CTRL_OFS || aw_addr == `ODSC_STAT_OFS
                || in_bank(aw_addr, `ODSC_DATA_BASE) || in_bank(aw_addr, `ODSC_CODE_BASE)) begin
               s_axi_bresp <= `ODSC_RESP_OKAY;
            end else begin
               s_axi_bresp <= `ODSC_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         link_en <= `ODSC_CTRL_RST;
      end else if (aw_got && w_got && !s_axi_bvalid && aw_addr == `ODSC_CTRL_OFS
                   && w_strb[0]) begin
         link_en <= w_data[`ODSC_CTRL_EN_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `ODSC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `ODSC_RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
         if (s_axi_araddr == `ODSC_CTRL_OFS) begin
            s_axi_rdata[`ODSC_CTRL_EN_BIT] <= link_en;
         end else if (s_axi_araddr == `ODSC_STAT_OFS) begin
            s_axi_rdata[`ODSC_STAT_MODE]  <= write_through_mode;
            s_axi_rdata[`ODSC_STAT_BUSY]  <= (st == odsc_pkg::ODSC_FRAME);
            s_axi_rdata[`ODSC_STAT_ABORT] <= last_abort;
            s_axi_rdata[15:8]             <= exec_count;
         end else if (in_bank(s_axi_araddr, `ODSC_DATA_BASE)) begin
            s_axi_rdata[9:0] <= data_reg[s_axi_araddr[4:2]];
         end else if (in_bank(s_axi_araddr, `ODSC_CODE_BASE)) begin
            s_axi_rdata[9:0] <= dac_code[s_axi_araddr[4:2]];
         end else begin
            s_axi_rresp <= `ODSC_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_exec_load;
      exec && !shreg[15];
   endsequence
   sequence s_exec_op(logic [3:0] code);
      exec && op == code;
   endsequence

   AST_SHIFT_MSB_FIRST: assert property (shift_en |=> shreg == {$past(shreg[14:0]), $past(din_f)})
      else $error("shift register did not take the data bit");
   AST_ABORT_KEEPS: assert property (abort |=> $stable(data_reg) && $stable(dac_code)
                                     && $stable(write_through_mode))
      else $error("aborted frame changed state");
   AST_WRITE_THROUGH: assert property (s_exec_load ##0 write_through_mode
                                       |=> dac_code[$past(ch)] == $past(val))
      else $error("write-through load did not reach the output");
   AST_REG_ONLY_HOLDS: assert property (s_exec_load ##0 !write_through_mode
                                        |=> $stable(dac_code) ##1 $stable(dac_code))
      else $error("register-only load moved an output");
   AST_MODE_SET: assert property (s_exec_op(`ODSC_OP_WR_THRU) |=> write_through_mode)
      else $error("write-through mode not entered");
   AST_MODE_CLR: assert property (s_exec_op(`ODSC_OP_REG_ONLY) |=> !write_through_mode)
      else $error("register-only mode not entered");
   AST_UPDATE_ALL: assert property (s_exec_op(`ODSC_OP_UPD_ALL) |=> dac_code == $past(data_reg))
      else $error("simultaneous update failed");
   AST_CHA_UPDATE: assert property (s_exec_op(`ODSC_OP_CHA_UPD) |=> data_reg[0] == $past(val)
                                    && dac_code[0] == $past(val)
                                    && $stable(write_through_mode))
      else $error("channel A update failed");
   AST_DOUT_MARK: assert property (shift_en && cnt == `ODSC_ABORT_EDGES |=> dout)
      else $error("dout not high after fifteenth edge");
   AST_SHORT_NO_EXEC: assert property (sync_rise && cnt != `ODSC_FULL_EDGES
                                       && cnt < 8'h20 |-> !exec)
      else $error("incomplete frame executed");
   AST_RESET_CLEAR: assert property (disable iff (1'b0) !reset_n |=> dac_code == '0
                                     && data_reg == '0 && cnt == 8'h00)
      else $error("reset did not clear channels");
endmodule
`default_nettype wire

// ---- bench/odsc_host_model.sv ----
// host serial master model driving the three-wire link
`timescale 1ns/1ps
`default_nettype none
module odsc_host_model (
   output logic      sclk,
   output logic      sync_n,
   output logic      din,
   input  wire logic dout
);
   logic [63:0] echo;

   initial begin
      sclk   = 1'b1;
      sync_n = 1'b1;
      din    = 1'b0;
      echo   = '0;
   end

   // send the low n bits of w; echo collects dout seen after each fall
   task automatic send(input logic [63:0] w, input int n);
      sync_n = 1'b0;
      #150;
      for (int i = n - 1; i >= 0; i--) begin
         din = w[i];
         #2.5 sclk = 1'b0;
         #62.5 sclk = 1'b1;
         #60 echo = {echo[62:0], dout};
      end
      sync_n = 1'b1;
      din    = 1'b0;
      #300;
   endtask
endmodule
`default_nettype wire

// ---- bench/test_octal_dac_serial_control.sv ----
// self-checking bench of the octal converter serial control block
`timescale 1ns/1ps
`default_nettype none
`include "odsc_defs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   $display("[FAIL] %s exp %h got %h", nm, e, g); error_cnt++; end end
module test_octal_dac_serial_control;
   logic              clk, reset_n, sclk, sync_n, din, dout;
   logic [7:0][9:0]   code;
   logic [7:0]        awaddr, araddr;
   logic [31:0]       wdata, rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [15:0]       w1, w2;
   int                error_cnt, checks_done, ch;

   odsc_top DUT (
      .clk(clk), .reset_n(reset_n), .sclk(sclk), .sync_n(sync_n), .din(din),
      .dout(dout), .dac_code(code),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   odsc_host_model host (
      .sclk(sclk),
      .sync_n(sync_n),
      .din(din),
      .dout(dout)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic hang;
      error_cnt++;
      $display("[FAIL] bus wait exp answer got none");
      print_verdict;
   endtask

   function automatic logic [9:0] cd(input int c);
      return 10'h3ff - 10'(c * 32'h92);
   endfunction

   function automatic logic [15:0] lw(input int c, input logic [9:0] v);
      return {1'b0, 3'(c), v, 2'b00};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, wd, dn;
      aw = 1'b0;
      wd = 1'b0;
      dn = 1'b0;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 50 && !dn; n++) begin
         @(posedge clk);
         if (!aw && awready) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            dn = 1'b1;
            bready <= 1'b0;
            `CHK("bresp", er, bresp)
         end
      end
      if (!dn) hang;
      @(posedge clk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                       input logic [31:0] m = 32'hffffffff);
      logic ad, dn;
      ad = 1'b0;
      dn = 1'b0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 50 && !dn; n++) begin
         @(posedge clk);
         if (!ad && arready) begin
            ad = 1'b1;
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            dn = 1'b1;
            rready <= 1'b0;
            `CHK("rdata", e, rdata & m)
            `CHK("rresp", er, rresp)
         end
      end
      if (!dn) hang;
      @(posedge clk);
   endtask

   task automatic frame(input logic [63:0] w, input int n);
      host.send(w, n);
      repeat (20) @(posedge clk);
   endtask

   task automatic fin(input string s);
      $display("test %s ends, mismatches %0d", s, error_cnt);
   endtask

   initial begin
      reset_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      error_cnt = 0;
      checks_done = 0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      for (ch = 0; ch < 8; ch++) `CHK("code", 10'h000, code[ch])
      `CHK("dout", 1'b0, dout)
      rchk(`ODSC_STAT_OFS, 32'h0, `ODSC_RESP_OKAY);
      rchk(`ODSC_CTRL_OFS, 32'h1, `ODSC_RESP_OKAY);
      rchk(8'h10, 32'h0, `ODSC_RESP_SLVERR);
      wr(8'h10, 32'h0, `ODSC_RESP_SLVERR);
      fin("reset");
      for (ch = 0; ch < 8; ch++) begin
         frame(64'(lw(ch, cd(ch))), 16);
         `CHK("echo", 16'h0002, host.echo[15:0])
         `CHK("code", 10'h000, code[ch])
         rchk(`ODSC_DATA_BASE + 8'(4 * ch), 32'(cd(ch)), `ODSC_RESP_OKAY);
      end
      fin("load");
      frame(64'ha000, 16);
      for (ch = 0; ch < 8; ch++) `CHK("code", cd(ch), code[ch])
      frame(64'h9000, 16);
      rchk(`ODSC_STAT_OFS, 32'h1, `ODSC_RESP_OKAY, 32'h1);
      frame(64'(lw(5, 10'h155)), 16);
      `CHK("code", 10'h155, code[5])
      rchk(`ODSC_CODE_BASE + 8'h14, 32'h155, `ODSC_RESP_OKAY);
      `CHK("code", cd(4), code[4])
      frame(64'h8000, 16);
      frame(64'(lw(1, 10'h0ab)), 16);
      `CHK("code", cd(1), code[1])
      frame(64'hbaa8, 16);
      `CHK("code", 10'h2aa, code[0])
      `CHK("code", 10'h0ab, code[1])
      rchk(`ODSC_STAT_OFS, 32'h0, `ODSC_RESP_OKAY, 32'h1);
      fin("modes");
      frame(64'(lw(2, 10'h001)) >> 2, 14);
      rchk(`ODSC_STAT_OFS, 32'h4, `ODSC_RESP_OKAY, 32'h4);
      frame(64'(lw(2, 10'h001)) >> 8, 8);
      rchk(`ODSC_STAT_OFS, 32'h4, `ODSC_RESP_OKAY, 32'h4);
      rchk(`ODSC_DATA_BASE + 8'h08, 32'(cd(2)), `ODSC_RESP_OKAY);
      `CHK("code", cd(2), code[2])
      fin("abort");
      w1 = lw(4, 10'h3c3);
      w2 = lw(6, 10'h24a);
      frame({32'h0, w1, w2}, 32);
      `CHK("echo", {14'h0, 1'b1, w1, w2[15]}, host.echo[31:0])
      rchk(`ODSC_DATA_BASE + 8'h18, 32'h24a, `ODSC_RESP_OKAY);
      rchk(`ODSC_DATA_BASE + 8'h10, 32'(cd(4)), `ODSC_RESP_OKAY);
      `CHK("code", cd(6), code[6])
      fin("daisy");
      wr(`ODSC_CTRL_OFS, 32'h0, `ODSC_RESP_OKAY);
      frame(64'(lw(7, 10'h111)), 16);
      rchk(`ODSC_DATA_BASE + 8'h1c, 32'(cd(7)), `ODSC_RESP_OKAY);
      rchk(`ODSC_STAT_OFS, 32'h0f00, `ODSC_RESP_OKAY, 32'hff00);
      wr(`ODSC_CTRL_OFS, 32'h1, `ODSC_RESP_OKAY);
      rchk(`ODSC_CTRL_OFS, 32'h1, `ODSC_RESP_OKAY);
      fin("ctrl");
      print_verdict;
   end
endmodule
`default_nettype wire
